/* File: dims_cfg.svh */
/*
  offsets, field positions, reset values and encodings of the dma and
  interrupt mode select block.
  assumes inclusion by bare name from the package and the top module.
*/
`ifndef DIMS_CFG_SVH
`define DIMS_CFG_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define DIMS_OFS_CTRL        8'h00
`define DIMS_OFS_CONF        8'h04
`define DIMS_OFS_STAT        8'h08
`define DIMS_OFS_ROUTE       8'h0c

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define DIMS_CTRL_W          10
`define DIMS_CTRL_IRQSEL_LSB 0
`define DIMS_CTRL_IRQSEL_MSB 2
`define DIMS_CTRL_SENSE_BIT  3
`define DIMS_CTRL_DAC0_BIT   4
`define DIMS_CTRL_DAC1_BIT   5
`define DIMS_CTRL_MODE_LSB   4
`define DIMS_CTRL_MODE_MSB   9
`define DIMS_CTRL_RST        10'h000

// ----------------------------------------------------------------
// configuration and status fields
// ----------------------------------------------------------------
`define DIMS_CONF_NONREF_SINGLE_ENDED_CONFIG_BIT   0
`define DIMS_CONF_RST        1'b0
`define DIMS_STAT_IRQ_BIT    0

// ----------------------------------------------------------------
// pending source bits
// ----------------------------------------------------------------
`define DIMS_PEND_ADC        0
`define DIMS_PEND_DAC0       1
`define DIMS_PEND_DAC1       2

// ----------------------------------------------------------------
// bus responses
// ----------------------------------------------------------------
`define DIMS_RESP_OKAY       2'b00
`define DIMS_RESP_SLVERR     2'b10

// ----------------------------------------------------------------
// host interrupt levels per select code
// ----------------------------------------------------------------
`define DIMS_LVL_0           4'h3
`define DIMS_LVL_1           4'h4
`define DIMS_LVL_2           4'h5
`define DIMS_LVL_3           4'h7
`define DIMS_LVL_4           4'ha
`define DIMS_LVL_5           4'hb
`define DIMS_LVL_6           4'hc
`define DIMS_LVL_7           4'hf

`endif

/* File: dims_pkg.sv */
/*
  types of the dma and interrupt mode select block.
  assumes dims_cfg.svh on the include path.
*/
package dims_pkg;
  `include "dims_cfg.svh"

  typedef enum logic [2:0] {
    DIMS_SRC_NONE  = 3'h0,
    DIMS_SRC_DAC0  = 3'h1,
    DIMS_SRC_DAC1  = 3'h2,
    DIMS_SRC_DAC01 = 3'h3,
    DIMS_SRC_ADC   = 3'h4
  } dims_src_t;

  typedef struct packed {
    dims_src_t src_a;
    dims_src_t src_b;
    logic      dbl_buf;
    logic      sync_dual;
    logic      irq_adc;
    logic      irq_timer;
  } dims_route_t;

  typedef enum logic [1:0] {
    DIMS_RD_IDLE = 2'b01,
    DIMS_RD_DATA = 2'b10
  } dims_rd_t;

  typedef struct packed {
    logic [9:0]  ctrl;
    logic        nonref_single_ended_config;
    logic        aw_got;
    logic [7:0]  awaddr;
    logic        w_got;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    dims_rd_t    rd;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [2:0]  pend;
    logic        dac_turn;
    logic        ab_sel;
    logic        irq_pend;
  } dims_state_t;
endpackage

/* File: dims_route_if.sv */
/*
  carries the six-bit mode code to the decoder and the routing back.
  assumes both ends in the same clock domain; the path is combinational.
*/
`timescale 1ns/1ps
interface dims_route_if;
  import dims_pkg::*;
  logic [5:0]  mode;
  dims_route_t route;
  modport dec (input mode, output route);
  modport usr (output mode, input route);
endinterface

/* File: dims_route_decoder.sv */
/*
  decodes the mode code into channel sources and interrupt causes.
  assumes the mode code order int, chan a, chan b, adc, dac1, dac0.
*/
`timescale 1ns/1ps
module dims_route_decoder
  import dims_pkg::*;
(
  // mode in, routing out
  dims_route_if.dec rif
);

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  function automatic dims_src_t dims_dac_src(input logic [1:0] dac);
    case (dac)
      2'b01:   dims_dac_src = DIMS_SRC_DAC0;
      2'b10:   dims_dac_src = DIMS_SRC_DAC1;
      2'b11:   dims_dac_src = DIMS_SRC_DAC01;
      default: dims_dac_src = DIMS_SRC_NONE;
    endcase
  endfunction

  logic       im;
  logic       cha;
  logic       chb;
  logic       adc;
  logic [1:0] dac;

  assign {im, cha, chb, adc, dac} = rif.mode;

  always_comb begin
    rif.route = '0;
    if (!cha && !chb) begin
      rif.route.irq_adc   = im & adc;
      rif.route.irq_timer = im & (dac != 2'b00);
    end else if (cha ^ chb) begin
      if (adc && dac == 2'b00) begin
        if (cha) begin
          rif.route.src_a = DIMS_SRC_ADC;
        end else begin
          rif.route.src_b = DIMS_SRC_ADC;
        end
        rif.route.irq_timer = im;
      end else if (!adc && dac != 2'b00) begin
        if (cha) begin
          rif.route.src_a = dims_dac_src(dac);
        end else begin
          rif.route.src_b = dims_dac_src(dac);
        end
        rif.route.irq_adc = im;
      end
    end else if (!adc) begin
      rif.route.irq_adc = im;
      if (dac == 2'b11) begin
        rif.route.src_a     = DIMS_SRC_DAC0;
        rif.route.src_b     = DIMS_SRC_DAC1;
        rif.route.sync_dual = 1'b1;
      end else begin
        rif.route.src_a   = (dac == 2'b00) ? DIMS_SRC_DAC01 : dims_dac_src(dac);
        rif.route.src_b   = rif.route.src_a;
        rif.route.dbl_buf = 1'b1;
      end
    end else if (dac == 2'b00) begin
      rif.route.src_a     = DIMS_SRC_ADC;
      rif.route.src_b     = DIMS_SRC_ADC;
      rif.route.dbl_buf   = 1'b1;
      rif.route.irq_timer = im;
    end else if (im) begin
      rif.route.src_a = dims_dac_src(dac);
      rif.route.src_b = DIMS_SRC_ADC;
    end else begin
      rif.route.src_a = DIMS_SRC_ADC;
      rif.route.src_b = dims_dac_src(dac);
    end
  end

endmodule

/* File: dims_mode_select.sv */
/*
  dma and interrupt mode select: axi4-lite registers, dma request
  routing for two channels, host interrupt level steering, sense pin drive.
  assumes event inputs are one-cycle pulses synchronous to aclk and that
  the host dma controller raises an ack for one cycle per transfer.
*/
`timescale 1ns/1ps
`include "dims_cfg.svh"

// Contract
// - decode six-bit mode code into routing
// - 101010: channel b feeds dac1, adc interrupt
// - 101011: channel b feeds both dacs, adc interrupt
// - 101100: adc out on channel b, timer interrupt
// - 111000: a/b double-buffer both dacs, adc interrupt
// - 111001/111010: a/b double-buffer one dac
// - 111011: a/b synchronized to both dacs
// - 111100: adc double-buffered on a/b, timer interrupt
// - 111101-111111: a feeds dacs, b carries adc
// - dac1 enable gates dac1 requests, except 111000/011000, which double-buffer both dacs
// - dac0 enable gates dac0 requests, except 111000/011000, which double-buffer both dacs
// - sense pin grounded only when enabled, not nonref_single_ended_config
// - select code maps to host interrupt level
module dims_mode_select
  import dims_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output      logic        s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output      logic        s_axi_wready,
  // axi4-lite write response
  output      logic [1:0]  s_axi_bresp,
  output      logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output      logic        s_axi_arready,
  // axi4-lite read data
  output      logic [31:0] s_axi_rdata,
  output      logic [1:0]  s_axi_rresp,
  output      logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // converter and timer events
  input  wire logic        adc_done,
  input  wire logic        timer_event,
  input  wire logic        dac0_ready,
  input  wire logic        dac1_ready,
  // host dma handshake
  output      logic        dma_req_a,
  input  wire logic        dma_ack_a,
  output      logic        dma_req_b,
  input  wire logic        dma_ack_b,
  // host interrupt lines, one per select code
  output      logic [7:0]  irq_o,
  output      logic [7:0]  irq_oe_n,
  // analog sense pin
  input  wire logic        sense_i,
  output      logic        sense_o,
  output      logic        sense_oe_n
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] dims_merge(input logic [31:0] old,
                                             input logic [31:0] data,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    dims_merge = res;
  endfunction

  function automatic logic [3:0] dims_level(input logic [2:0] sel);
    case (sel)
      3'h0:    dims_level = `DIMS_LVL_0;
      3'h1:    dims_level = `DIMS_LVL_1;
      3'h2:    dims_level = `DIMS_LVL_2;
      3'h3:    dims_level = `DIMS_LVL_3;
      3'h4:    dims_level = `DIMS_LVL_4;
      3'h5:    dims_level = `DIMS_LVL_5;
      3'h6:    dims_level = `DIMS_LVL_6;
      default: dims_level = `DIMS_LVL_7;
    endcase
  endfunction

  // one-hot pending source that a channel with this source would serve
  function automatic logic [2:0] dims_pick(input dims_src_t s,
                                           input logic [2:0] pend,
                                           input logic       turn);
    case (s)
      DIMS_SRC_ADC:   dims_pick = pend & 3'h1;
      DIMS_SRC_DAC0:  dims_pick = pend & 3'h2;
      DIMS_SRC_DAC1:  dims_pick = pend & 3'h4;
      DIMS_SRC_DAC01: begin
        if (pend[2:1] == 2'b11) begin
          dims_pick = turn ? 3'h4 : 3'h2;
        end else begin
          dims_pick = pend & 3'h6;
        end
      end
      default:        dims_pick = 3'h0;
    endcase
  endfunction

  function automatic logic [2:0] dims_uses(input dims_src_t s);
    case (s)
      DIMS_SRC_ADC:   dims_uses = 3'h1;
      DIMS_SRC_DAC0:  dims_uses = 3'h2;
      DIMS_SRC_DAC1:  dims_uses = 3'h4;
      DIMS_SRC_DAC01: dims_uses = 3'h6;
      default:        dims_uses = 3'h0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  dims_state_t st_ff;
  dims_state_t nxt_st;
  dims_route_t route;

  dims_route_if rif ();

  assign rif.mode = st_ff.ctrl[`DIMS_CTRL_MODE_MSB:`DIMS_CTRL_MODE_LSB];
  assign route    = rif.route;

  dims_route_decoder u_dec (
    .rif (rif)
  );

  // ----------------------------------------------------------------
  // request routing
  // ----------------------------------------------------------------
  logic [2:0] pick_a;
  logic [2:0] pick_b;
  logic [2:0] served;
  logic       dac_ints;
  logic       req_a;
  logic       req_b;
  logic [2:0] irq_sel;

  assign pick_a   = dims_pick(route.src_a, st_ff.pend, st_ff.dac_turn);
  assign pick_b   = dims_pick(route.src_b, st_ff.pend, st_ff.dac_turn);
  // dac sources only reach a channel through their enable bits, except
  // the double-buffered both-dacs code, which names both dacs itself
  assign served   = dims_uses(route.src_a) | dims_uses(route.src_b);
  // with no channel enabled and the int bit clear, a dac request becomes a host interrupt
  assign dac_ints = (rif.mode[4:3] == 2'b00) && !rif.mode[5];

  always_comb begin
    if (route.sync_dual) begin
      req_a = st_ff.pend[`DIMS_PEND_DAC0] & st_ff.pend[`DIMS_PEND_DAC1];
      req_b = req_a;
    end else if (route.dbl_buf) begin
      req_a = (pick_a != 3'h0) && !st_ff.ab_sel;
      req_b = (pick_b != 3'h0) && st_ff.ab_sel;
    end else begin
      req_a = (pick_a != 3'h0);
      req_b = (pick_b != 3'h0);
    end
  end

  assign dma_req_a = req_a;
  assign dma_req_b = req_b;

  // ----------------------------------------------------------------
  // host interrupt and sense pin
  // ----------------------------------------------------------------
  assign irq_sel = st_ff.ctrl[`DIMS_CTRL_IRQSEL_MSB:`DIMS_CTRL_IRQSEL_LSB];
  assign irq_o   = {8{st_ff.irq_pend}};

  always_comb begin
    irq_oe_n = 8'hff;
    irq_oe_n[irq_sel] = 1'b0;
  end

  // ground is the only level ever driven; nonref_single_ended_config always wins
  assign sense_o    = 1'b0;
  assign sense_oe_n = !(st_ff.ctrl[`DIMS_CTRL_SENSE_BIT] && !st_ff.nonref_single_ended_config);

  // ----------------------------------------------------------------
  // bus outputs
  // ----------------------------------------------------------------
  assign s_axi_awready = !st_ff.aw_got && !st_ff.bvalid;
  assign s_axi_wready  = !st_ff.w_got && !st_ff.bvalid;
  assign s_axi_bvalid  = st_ff.bvalid;
  assign s_axi_bresp   = st_ff.bresp;
  assign s_axi_arready = (st_ff.rd == DIMS_RD_IDLE);
  assign s_axi_rvalid  = (st_ff.rd == DIMS_RD_DATA);
  assign s_axi_rdata   = st_ff.rdata;
  assign s_axi_rresp   = st_ff.rresp;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic        aw_hs;
  logic        w_hs;
  logic        aw_eff;
  logic        w_eff;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic [2:0]  clr;
  logic [2:0]  set;
  logic        irq_set;
  logic        irq_clr;
  logic [31:0] rd_word;
  logic        rd_ok;
  logic [31:0] ctrl_word;

  always_comb begin
    nxt_st  = st_ff;
    aw_hs   = s_axi_awvalid && s_axi_awready;
    w_hs    = s_axi_wvalid && s_axi_wready;
    aw_eff  = st_ff.aw_got || aw_hs;
    w_eff   = st_ff.w_got || w_hs;
    wr_addr = st_ff.aw_got ? st_ff.awaddr : s_axi_awaddr;
    wr_data = st_ff.w_got ? st_ff.wdata : s_axi_wdata;
    wr_strb = st_ff.w_got ? st_ff.wstrb : s_axi_wstrb;
    irq_clr = 1'b0;
    clr     = 3'h0;
    rd_word = 32'h0000_0000;
    rd_ok   = 1'b1;
    ctrl_word = 32'h0000_0000;

    // write: address and data in either order, response after both
    if (aw_eff && w_eff && !st_ff.bvalid) begin
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got  = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp  = `DIMS_RESP_OKAY;
      case (wr_addr)
        `DIMS_OFS_CTRL:  begin
          ctrl_word   = dims_merge({22'h0, st_ff.ctrl}, wr_data, wr_strb);
          nxt_st.ctrl = ctrl_word[9:0];
        end
        `DIMS_OFS_CONF:  begin
          if (wr_strb[0]) begin
            nxt_st.nonref_single_ended_config = wr_data[`DIMS_CONF_NONREF_SINGLE_ENDED_CONFIG_BIT];
          end
        end
        `DIMS_OFS_STAT:  irq_clr = wr_strb[0] && wr_data[`DIMS_STAT_IRQ_BIT];
        `DIMS_OFS_ROUTE: nxt_st.bresp = `DIMS_RESP_OKAY;
        default:         nxt_st.bresp = `DIMS_RESP_SLVERR;
      endcase
    end else begin
      if (aw_hs) begin
        nxt_st.aw_got = 1'b1;
        nxt_st.awaddr = s_axi_awaddr;
      end
      if (w_hs) begin
        nxt_st.w_got = 1'b1;
        nxt_st.wdata = s_axi_wdata;
        nxt_st.wstrb = s_axi_wstrb;
      end
    end
    if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end

    // read: one outstanding, data one cycle after the address
    case (s_axi_araddr)
      `DIMS_OFS_CTRL:  rd_word = {22'h0, st_ff.ctrl};
      `DIMS_OFS_CONF:  rd_word = {31'h0, st_ff.nonref_single_ended_config};
      `DIMS_OFS_STAT:  rd_word = {20'h0, st_ff.ab_sel, st_ff.pend,
                                  dims_level(irq_sel), sense_i, req_b, req_a,
                                  st_ff.irq_pend};
      `DIMS_OFS_ROUTE: rd_word = {22'h0, route};
      default:         rd_ok   = 1'b0;
    endcase
    case (st_ff.rd)
      DIMS_RD_IDLE: begin
        if (s_axi_arvalid) begin
          nxt_st.rd    = DIMS_RD_DATA;
          nxt_st.rdata = rd_word;
          nxt_st.rresp = rd_ok ? `DIMS_RESP_OKAY : `DIMS_RESP_SLVERR;
        end
      end
      DIMS_RD_DATA: begin
        if (s_axi_rready) begin
          nxt_st.rd = DIMS_RD_IDLE;
        end
      end
      default: nxt_st.rd = DIMS_RD_IDLE;
    endcase

    // dma acks retire one pending source each
    if (dma_ack_a && req_a) begin
      clr = clr | (route.sync_dual ? 3'h2 : pick_a);
    end
    if (dma_ack_b && req_b) begin
      clr = clr | (route.sync_dual ? 3'h4 : pick_b);
    end
    if (route.dbl_buf && ((dma_ack_a && req_a) || (dma_ack_b && req_b))) begin
      nxt_st.ab_sel = !st_ff.ab_sel;
    end
    if (clr[2:1] != 2'b00 && (route.src_a == DIMS_SRC_DAC01 ||
                              route.src_b == DIMS_SRC_DAC01)) begin
      nxt_st.dac_turn = !st_ff.dac_turn;
    end

    // events arriving with a clear still count
    set = {dac1_ready, dac0_ready, adc_done} & served;
    nxt_st.pend = ((st_ff.pend & ~clr) | set) & served;

    irq_set = (adc_done && route.irq_adc) ||
              (timer_event && route.irq_timer) ||
              (dac_ints && dac1_ready && st_ff.ctrl[`DIMS_CTRL_DAC1_BIT]) ||
              (dac_ints && dac0_ready && st_ff.ctrl[`DIMS_CTRL_DAC0_BIT]);
    nxt_st.irq_pend = (st_ff.irq_pend && !irq_clr) || irq_set;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff      <= '0;
      st_ff.ctrl <= `DIMS_CTRL_RST;
      st_ff.nonref_single_ended_config <= `DIMS_CONF_RST;
      st_ff.rd   <= DIMS_RD_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

endmodule

/* File: dims_mode_select_monitor.sv */
/*
  port assertions of the dma and interrupt mode select block.
  assumes full-word writes with aw and w offered together; wstrb unseen.
*/
`timescale 1ns/1ps
module dims_monitor
  import dims_pkg::*;
(
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // register bus
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // events and dma
  input wire logic        adc_done,
  input wire logic        timer_event,
  input wire logic        dac0_ready,
  input wire logic        dac1_ready,
  input wire logic        dma_req_a,
  input wire logic        dma_req_b,
  input wire logic        dma_ack_b,
  // pins
  input wire logic [7:0]  irq_o,
  input wire logic [7:0]  irq_oe_n,
  input wire logic        sense_o,
  input wire logic        sense_oe_n
);
  // ----------------------------------------------------------------
  // shadow of control and config
  // ----------------------------------------------------------------
  logic [9:0] ctrl_ff;
  logic       nonref_single_ended_config_ff;
  logic [5:0] mode;
  logic       wr_go;
  assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  assign mode  = ctrl_ff[9:4];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff <= 10'h000;
      nonref_single_ended_config_ff <= 1'b0;
    end else if (wr_go && s_axi_awaddr == 8'h00) begin
      ctrl_ff <= s_axi_wdata[9:0];
    end else if (wr_go && s_axi_awaddr == 8'h04) begin
      nonref_single_ended_config_ff <= s_axi_wdata[0];
    end
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_take;
    wr_go;
  endsequence
  sequence s_b_served;
    mode == 6'b101010 && dma_req_b && dma_ack_b && !dac1_ready;
  endsequence
  AST_IRQ_LINE: assert property (irq_oe_n == ~(8'h01 << ctrl_ff[2:0]))
    else $error("irq line enables wrong");
  AST_SENSE: assert property (sense_oe_n == !(ctrl_ff[3] && !nonref_single_ended_config_ff) && !sense_o)
    else $error("sense pin drive wrong");
  AST_DAC1_B: assert property (mode == 6'b101010 && dac1_ready |=> dma_req_b)
    else $error("dac1 request missing on b");
  AST_DAC0_GATE: assert property (mode == 6'b101010 && dac0_ready && !dac1_ready
    && !dma_req_b |=> !dma_req_b) else $error("dac0 request not gated");
  AST_ADC_IRQ: assert property (mode == 6'b101010 && adc_done |=> irq_o == 8'hff)
    else $error("adc interrupt missing");
  AST_ADC_B: assert property (mode == 6'b101100 && adc_done |=> dma_req_b)
    else $error("adc request missing on b");
  AST_TIMER_IRQ: assert property (mode == 6'b101100 && timer_event |=> irq_o[0])
    else $error("timer interrupt missing");
  AST_SYNC: assert property (mode == 6'b111011 |-> dma_req_a == dma_req_b)
    else $error("sync channels differ");
  AST_DAC0_A: assert property (mode == 6'b111101 && dac0_ready |=> dma_req_a)
    else $error("dac0 request missing on a");
  AST_ACK_B: assert property (s_b_served |=> !dma_req_b)
    else $error("request kept after ack");
  AST_B_ANSWER: assert property (s_wr_take |=> s_axi_bvalid)
    else $error("write response late");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
endmodule

/* File: dims_host_dma.sv */
/*
  host dma controller model: one-cycle ack per request, lag+1 cycles after the request is seen.
  assumes requests are levels that drop the cycle after an ack.
*/
`timescale 1ns/1ps
module dims_host_dma (
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // bench control
  input  wire logic       en,
  input  wire logic [3:0] lag,
  // handshake, bit 1 channel a
  input  wire logic [1:0] req,
  output      logic [1:0] ack
);
  logic [3:0] cnt_ff [2];
  // skips the cycle after an ack, since req is still up then
  always_ff @(posedge aclk) begin
    for (int i = 0; i < 2; i++) begin
      if (!aresetn || !en || !req[i] || ack[i]) begin
        ack[i]    <= 1'b0;
        cnt_ff[i] <= 4'h0;
      end else if (cnt_ff[i] == lag) begin
        ack[i] <= 1'b1;
      end else begin
        cnt_ff[i] <= cnt_ff[i] + 4'h1;
      end
    end
  end
endmodule

/* File: test_dma_irq_mode_select.sv */
/*
  testbench of the dma and interrupt mode select block.
  assumes the package, design, host dma model and monitor compiled first.
*/
`timescale 1ns/1ps
`include "dims_cfg.svh"
module test_dma_irq_mode_select
  import dims_pkg::*;
;
  logic        aclk = 1'b0, aresetn = 1'b0, sense_ext = 1'b1, dma_en = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb = 4'hf, dma_lag = 4'h0;
  logic        adc_done = 1'b0, timer_event = 1'b0, dac0_ready = 1'b0, dac1_ready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, dma_ack, rsp;
  logic        dma_req_a, dma_req_b, dma_ack_a, dma_ack_b, sense_o, sense_oe_n, sense_i;
  logic [7:0]  irq_o, irq_oe_n, e;
  logic        ch, ch2;
  int          err_total = 0, num_checks = 0;
  logic [3:0]  lvl [8] = '{4'h3, 4'h4, 4'h5, 4'h7, 4'ha, 4'hb, 4'hc, 4'hf};
  // ctrl[19:8], events {timer,dac1,dac0,adc}, flags {one of a/b, a, b, irq}
  logic [19:0] tab [27] = '{
    20'h2a042, 20'h2a011, 20'h2a020, 20'h2a080,
    20'h2b022, 20'h2b042, 20'h2c012, 20'h2c081,
    20'h3802a, 20'h38011, 20'h3902a, 20'h3a04a,
    20'h39040, 20'h3b066, 20'h3c01a, 20'h3c081,
    20'h3d024, 20'h3e044, 20'h3f064, 20'h3f012,
    20'h3d040, 20'h02041, 20'h01040, 20'h01021,
    20'h11024, 20'h1d014, 20'h21081
  };
  assign dma_ack_a = dma_ack[1];
  assign dma_ack_b = dma_ack[0];
  // pin level: the block drives ground, else the outside level
  assign sense_i = sense_oe_n ? sense_ext : sense_o;
  always #5 aclk = ~aclk;
  dims_mode_select u_dims_mode_select (.*);
  dims_host_dma u_dims_host_dma (.aclk(aclk), .aresetn(aresetn), .en(dma_en),
    .lag(dma_lag), .req({dma_req_a, dma_req_b}), .ack(dma_ack));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic hang();
    err_total++;
    $display("MISMATCH t=%0t got=%h exp=%h wait ran out", $time, 1'b0, 1'b1);
    complete_run();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    if (n == 50) hang();
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a);
    int n;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    if (n == 50) hang();
    rd  = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic pulse(input logic [3:0] ev);
    @(posedge aclk);
    {timer_event, dac1_ready, dac0_ready, adc_done} <= ev;
    @(posedge aclk);
    {timer_event, dac1_ready, dac0_ready, adc_done} <= 4'h0;
  endtask
  task automatic serve(input logic [3:0] ev, output logic c);
    int n;
    pulse(ev);
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (dma_ack_a || dma_ack_b) break;
    end
    if (n == 40) hang();
    c = dma_ack_b;
    @(posedge aclk);
    chk({dma_req_a, dma_req_b}, 32'h0);
  endtask
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(irq_oe_n, 8'hfe);
    chk(sense_oe_n, 1'b1);
    rdr(`DIMS_OFS_CTRL);
    chk(rd, 32'h0);
    wr(8'h10, 32'h0000_00ff);
    chk(rsp, 2'b10);
    rdr(8'h10);
    chk(rsp, 2'b10);
    for (int i = 0; i < 8; i++) begin
      wr(`DIMS_OFS_CTRL, 32'(i));
      e = ~(8'h01 << i);
      chk(irq_oe_n, e);
      rdr(`DIMS_OFS_STAT);
      chk(rd[7:4], lvl[i]);
    end
    wr(`DIMS_OFS_CTRL, 32'h8);
    chk({sense_oe_n, sense_o}, 32'h0);
    rdr(`DIMS_OFS_STAT);
    chk(rd[3], 1'b0);
    wr(`DIMS_OFS_CONF, 32'h1);
    chk(sense_oe_n, 1'b1);
    rdr(`DIMS_OFS_STAT);
    chk(rd[3], 1'b1);
    wr(`DIMS_OFS_CONF, 32'h0);
    wr(`DIMS_OFS_CTRL, 32'h2a0);
    chk(sense_oe_n, 1'b1);
    rdr(`DIMS_OFS_ROUTE);
    chk(rd, 32'h22);
    foreach (tab[k]) begin
      wr(`DIMS_OFS_CTRL, 32'h0);
      wr(`DIMS_OFS_STAT, 32'h1);
      wr(`DIMS_OFS_CTRL, 32'(tab[k][19:8]));
      pulse(tab[k][7:4]);
      repeat (2) @(posedge aclk);
      chk(tab[k][3] ? {1'b0, dma_req_a ^ dma_req_b} : {dma_req_a, dma_req_b}, tab[k][2:1]);
      chk(irq_o, {8{tab[k][0]}});
    end
    // prompt and slow host, alternation survives both
    dma_en <= 1'b1;
    for (int l = 0; l < 2; l++) begin
      dma_lag <= 4'(3 * l);
      wr(`DIMS_OFS_CTRL, 32'h0);
      wr(`DIMS_OFS_CTRL, 32'h2a0);
      serve(4'h4, ch);
      chk(ch, 1'b1);
      wr(`DIMS_OFS_CTRL, 32'h380);
      serve(4'h2, ch);
      serve(4'h2, ch2);
      chk(ch2, !ch);
    end
    complete_run();
  end
endmodule
bind dims_mode_select dims_monitor u_dims_monitor (.*);
